// ---- common/msmc_pkg.sv ----
package msmc_pkg;

  // Sensors and widths
  localparam int NUM_SENSORS = 4;
  localparam int DATA_W      = 16;
  localparam int CODE_W      = 10;
  localparam int ADDR_W      = 8;
  localparam int ALARM_W     = 12;
  localparam int GAIN_MAG_W  = 6;

  // Measurement, maximum and minimum bases (one word per sensor)
  localparam logic [ADDR_W-1:0] MEAS_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] MAX_BASE  = 8'h20;
  localparam logic [ADDR_W-1:0] MIN_BASE  = 8'h24;

  // Calibration coefficient and flag words
  localparam logic [ADDR_W-1:0] SUPPLY_OFFSET_ADDR  = 8'h08;
  localparam logic [ADDR_W-1:0] BIPOLAR_OFFSET_ADDR = 8'h09;
  localparam logic [ADDR_W-1:0] GAIN_COEFF_ADDR     = 8'h0a;
  localparam logic [ADDR_W-1:0] FLAG_HIGH_ADDR      = 8'h3e;
  localparam logic [ADDR_W-1:0] FLAG_MAIN_ADDR      = 8'h3f;

  // Calibration channel
  localparam logic [5:0] CAL_CHANNEL = 6'h08;

  // Reset values
  localparam logic [DATA_W-1:0] MIN_RESET   = 16'hffff;
  localparam logic [DATA_W-1:0] MAX_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] COEFF_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 16'h0000;

  // Flag word and gain coefficient word field positions
  localparam int FLAG_OT_BIT   = 3;
  localparam int FLAG_REF_BIT  = 9;
  localparam int FLAG_DEBUG_ACCESS_READONLY_FLAG_BIT = 10;
  localparam int FLAG_DEBUG_ACCESS_DISABLED_FLAG_BIT = 11;
  localparam int GAIN_SIGN_BIT = 6;

  // Timing
  localparam int CLK_FREQ_MHZ   = 200;
  localparam int CONV_TIME_NS   = 1000;
  localparam int CONV_CYCLES    = (CONV_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CAL_CONV_GEN1  = 4;
  localparam int CAL_CONV_GEN2  = 10;
  localparam int CAL_CNT_W      = 12;

  // Calibration sequencer states
  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_RUN   = 2'b01,
    CAL_STORE = 2'b10
  } msmc_cal_state_type;

endpackage

// ---- design/msmc_status_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Each result stored as full 16 bits, 10-bit code in top bits.
// - One minimum and one maximum register per internal sensor.
// - Reset loads minimums with ffff and maximums with 0000.
// - A result above the stored maximum replaces it.
// - A result below the stored minimum replaces it.
// - Minimum and maximum checked on every stored result, none skipped.
// - Live alarm states shown: alarms 0-6 at 3f, 8-11 at 3e low nibble.
// - Over-temperature output shown in bit 3 of word 3f.
// - Reference flag high for internal reference, low for external.
// - Read-only debug access flag set when image restricts debug path.
// - Debug access disabled flag set when image turns debug path off.
// - Conversion on channel 8 computes coefficients into words 08 to 0a.
// - Correction applied in default mode, else only when enables set.
// - Busy stays high for the whole calibration sequence.
// - Calibration lasts four conversions, or ten on the later variant.
// - Coefficient words are read-only; port writes leave them unchanged.
// - Offset correction is 10-bit two's complement, top-justified.
// - Unipolar supply offset at 08, bipolar offset at 09.
// - Gain magnitude in bits 5 to 0 of 0a, 0.1 percent per count.
// - Gain sign in bit 6 of 0a, 1 positive, 0 negative.
// - Each coefficient is the negated measured error.
module msmc_status_bank
  import msmc_pkg::*;
#(
  parameter bit LATER_VARIANT = 1'b0
)
(
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // Configuration port
  input  wire logic                 CFG_EN,
  input  wire logic                 CFG_WE,
  input  wire logic [ADDR_W-1:0]    CFG_ADDR,
  input  wire logic [DATA_W-1:0]    CFG_DIN,
  output logic      [DATA_W-1:0]    CFG_DOUT,
  output logic                      CFG_RDY,
  // Conversion results from the converter
  input  wire logic                 MEAS_VALID,
  input  wire logic [1:0]           MEAS_SENSOR,
  input  wire logic [DATA_W-1:0]    MEAS_DATA,
  // Conversion requests and busy
  input  wire logic                 CONV_REQ,
  input  wire logic [5:0]           CONV_CHAN,
  output logic                      BUSY,
  // Measured errors from the calibration conversions
  input  wire logic [CODE_W-1:0]    CAL_ERR_SUPPLY,
  input  wire logic [CODE_W-1:0]    CAL_ERR_BIPOLAR,
  input  wire logic                 CAL_ERR_GAIN_POS,
  input  wire logic [GAIN_MAG_W-1:0] CAL_ERR_GAIN_MAG,
  // Mode and calibration enables
  input  wire logic                 DEFAULT_MODE,
  input  wire logic [3:0]           CALIBRATION_APPLY_ENABLES,
  output logic                      CAL_APPLIED,
  // Status sources
  input  wire logic [ALARM_W-1:0]   ALARM_STATUS_BITS,
  input  wire logic                 OVER_TEMPERATURE_FLAG,
  input  wire logic                 REF_INTERNAL,
  input  wire logic                 DEBUG_ACCESS_READONLY_FLAG,
  input  wire logic                 DEBUG_ACCESS_DISABLED_FLAG
);

  localparam int CAL_CONVS = LATER_VARIANT ? CAL_CONV_GEN2 : CAL_CONV_GEN1;
  localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CONVS * CONV_CYCLES - 1);

  logic [DATA_W-1:0] meas_reg [NUM_SENSORS];
  logic [DATA_W-1:0] max_reg  [NUM_SENSORS];
  logic [DATA_W-1:0] min_reg  [NUM_SENSORS];
  logic [DATA_W-1:0] meas_next [NUM_SENSORS];
  logic [DATA_W-1:0] max_next  [NUM_SENSORS];
  logic [DATA_W-1:0] min_next  [NUM_SENSORS];
  logic [DATA_W-1:0] supply_offset_coeff_reg, supply_offset_coeff_next;
  logic [DATA_W-1:0] bipolar_offset_coeff_reg, bipolar_offset_coeff_next;
  logic [DATA_W-1:0] gain_coeff_reg, gain_coeff_next;
  logic [DATA_W-1:0] flag_word_main_reg, flag_word_main_next;
  logic [DATA_W-1:0] flag_word_high_alarms_reg, flag_word_high_alarms_next;
  logic [DATA_W-1:0] res_val;
  logic              apply_next;
  logic              cal_start;
  msmc_cal_state_type     state_reg, state_next;
  logic [CAL_CNT_W-1:0]   cnt_reg, cnt_next;
  logic              busy_next;
  logic [DATA_W-1:0] dout_next;
  logic              rdy_next;

  assign apply_next = DEFAULT_MODE | (|CALIBRATION_APPLY_ENABLES);

  // full word stored, top-justified offset correction added when applied
  assign res_val = CAL_APPLIED ? DATA_W'(MEAS_DATA + supply_offset_coeff_reg) : MEAS_DATA;

  // Per-sensor result, maximum and minimum
  genvar g;
  generate
    for (g = 0; g < NUM_SENSORS; g++)
    begin : g_sensor
      always_comb
      begin
        meas_next[g] = meas_reg[g];
        max_next[g]  = max_reg[g];
        min_next[g]  = min_reg[g];
        if (MEAS_VALID && (MEAS_SENSOR == 2'(g)))
        begin
          meas_next[g] = res_val;
          if (res_val > max_reg[g])
            max_next[g] = res_val;
          if (res_val < min_reg[g])
            min_next[g] = res_val;
        end
      end

      always_ff @(posedge CLK or posedge RST)
      begin
        if (RST)
        begin
          meas_reg[g] <= MAX_RESET;
          max_reg[g]  <= MAX_RESET;
          min_reg[g]  <= MIN_RESET;
        end
        else
        begin
          meas_reg[g] <= meas_next[g];
          max_reg[g]  <= max_next[g];
          min_reg[g]  <= min_next[g];
        end
      end
    end
  endgenerate

  // Flag words, refreshed every cycle
  always_comb
  begin
    flag_word_main_next = '0;
    flag_word_high_alarms_next = '0;
    flag_word_main_next[2:0] = ALARM_STATUS_BITS[2:0];
    flag_word_main_next[7:4] = ALARM_STATUS_BITS[6:3];
    flag_word_high_alarms_next[3:0] = ALARM_STATUS_BITS[11:8];
    flag_word_main_next[FLAG_OT_BIT] = OVER_TEMPERATURE_FLAG;
    flag_word_main_next[FLAG_REF_BIT] = REF_INTERNAL;
    flag_word_main_next[FLAG_DEBUG_ACCESS_READONLY_FLAG_BIT] = DEBUG_ACCESS_READONLY_FLAG;
    flag_word_main_next[FLAG_DEBUG_ACCESS_DISABLED_FLAG_BIT] = DEBUG_ACCESS_DISABLED_FLAG;
  end

  // Calibration sequencer
  assign cal_start = CONV_REQ && (CONV_CHAN == CAL_CHANNEL) && (state_reg == CAL_IDLE);

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    supply_offset_coeff_next  = supply_offset_coeff_reg;
    bipolar_offset_coeff_next = bipolar_offset_coeff_reg;
    gain_coeff_next           = gain_coeff_reg;
    case (state_reg)
      CAL_IDLE:
      begin
        if (cal_start)
        begin
          state_next = CAL_RUN;
          cnt_next   = '0;
        end
      end
      CAL_RUN:
      begin
        if (cnt_reg == CAL_LAST)
          state_next = CAL_STORE;
        else
          cnt_next = cnt_reg + 1'b1;
      end
      CAL_STORE:
      begin
        supply_offset_coeff_next  = {CODE_W'(-CAL_ERR_SUPPLY), 6'h00};
        bipolar_offset_coeff_next = {CODE_W'(-CAL_ERR_BIPOLAR), 6'h00};
        gain_coeff_next = {9'h000, ~CAL_ERR_GAIN_POS, CAL_ERR_GAIN_MAG};
        state_next = CAL_IDLE;
      end
      default:
        state_next = CAL_IDLE;
    endcase
  end

  assign busy_next = (state_next != CAL_IDLE);

  // Read port; writes change nothing
  always_comb
  begin
    rdy_next  = CFG_EN;
    dout_next = CFG_DOUT;
    if (CFG_EN && !CFG_WE)
    begin
      dout_next = UNMAPPED_RD;
      for (int i = 0; i < NUM_SENSORS; i++)
      begin
        if (CFG_ADDR == MEAS_BASE + ADDR_W'(i))
          dout_next = meas_reg[i];
        if (CFG_ADDR == MAX_BASE + ADDR_W'(i))
          dout_next = max_reg[i];
        if (CFG_ADDR == MIN_BASE + ADDR_W'(i))
          dout_next = min_reg[i];
      end
      case (CFG_ADDR)
        SUPPLY_OFFSET_ADDR:  dout_next = supply_offset_coeff_reg;
        BIPOLAR_OFFSET_ADDR: dout_next = bipolar_offset_coeff_reg;
        GAIN_COEFF_ADDR:     dout_next = gain_coeff_reg;
        FLAG_HIGH_ADDR:      dout_next = flag_word_high_alarms_reg;
        FLAG_MAIN_ADDR:      dout_next = flag_word_main_reg;
        default:             dout_next = dout_next;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= CAL_IDLE;
      cnt_reg   <= '0;
      supply_offset_coeff_reg   <= COEFF_RESET;
      bipolar_offset_coeff_reg  <= COEFF_RESET;
      gain_coeff_reg            <= COEFF_RESET;
      flag_word_main_reg        <= '0;
      flag_word_high_alarms_reg <= '0;
      BUSY        <= 1'b0;
      CAL_APPLIED <= 1'b0;
      CFG_DOUT    <= '0;
      CFG_RDY     <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      supply_offset_coeff_reg   <= supply_offset_coeff_next;
      bipolar_offset_coeff_reg  <= bipolar_offset_coeff_next;
      gain_coeff_reg            <= gain_coeff_next;
      flag_word_main_reg        <= flag_word_main_next;
      flag_word_high_alarms_reg <= flag_word_high_alarms_next;
      BUSY        <= busy_next;
      CAL_APPLIED <= apply_next;
      CFG_DOUT    <= dout_next;
      CFG_RDY     <= rdy_next;
    end
  end

  // Checks
  localparam int CAL_WAIT = CAL_CONV_GEN2 * 200 + 3;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  minmax_reset_a: assert property ($past(RST) |-> min_reg[0] == MIN_RESET && max_reg[0] == MAX_RESET)
    else $error("min or max not at reset value after reset");
  max_update_a: assert property (MEAS_VALID && MEAS_SENSOR == 2'd0 && res_val > max_reg[0] |=> max_reg[0] == $past(res_val))
    else $error("maximum not updated by larger result");
  min_update_a: assert property (MEAS_VALID && MEAS_SENSOR == 2'd1 && res_val < min_reg[1] |=> min_reg[1] == $past(res_val))
    else $error("minimum not updated by smaller result");
  equal_hold_a: assert property (MEAS_VALID && MEAS_SENSOR == 2'd0 && res_val == max_reg[0] |=> $stable(max_reg[0]))
    else $error("maximum changed on equal result");
  ot_flag_a: assert property (##1 flag_word_main_reg[FLAG_OT_BIT] == $past(OVER_TEMPERATURE_FLAG))
    else $error("over-temperature flag does not follow source");
  busy_span_a: assert property (cal_start |=> BUSY [*8])
    else $error("busy dropped early in calibration");
  cal_end_a: assert property (cal_start |-> ##[1:CAL_WAIT] !BUSY)
    else $error("calibration did not finish in time");
  coeff_ro_a: assert property (CFG_EN && CFG_WE && state_reg == CAL_IDLE && !cal_start |=> $stable(gain_coeff_reg))
    else $error("coefficient changed by port write");
  gain_sign_a: assert property (state_reg == CAL_STORE |=> gain_coeff_reg[GAIN_SIGN_BIT] == !$past(CAL_ERR_GAIN_POS))
    else $error("gain sign not negated error sign");

  cal_done_c: cover property (state_reg == CAL_STORE ##1 !BUSY);
  max_new_c: cover property (MEAS_VALID && res_val > max_reg[MEAS_SENSOR]);
  flag_read_c: cover property (CFG_EN && !CFG_WE && CFG_ADDR == FLAG_MAIN_ADDR);

endmodule

`default_nettype wire

// ---- sim/msmc_cfg_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module msmc_cfg_master
  import msmc_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Answer from the port
  input  wire logic              cfg_rdy,
  input  wire logic [DATA_W-1:0] cfg_dout,
  // Request to the port
  output logic                   cfg_en,
  output logic                   cfg_we,
  output logic [ADDR_W-1:0]      cfg_addr,
  output logic [DATA_W-1:0]      cfg_din
);
  initial
  begin
    cfg_en = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_din = 16'h0000;
  end
  // One strobe per access; address and data held until the answer is taken
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    @(negedge clk);
    cfg_en = 1'b1;
    cfg_we = w;
    cfg_addr = a;
    cfg_din = d;
    @(negedge clk);
    cfg_en = 1'b0;
    while (cfg_rdy !== 1'b1 && n < 8)
    begin
      n++;
      @(negedge clk);
    end
    q = (n < 8) ? cfg_dout : 16'hxxxx;
    @(posedge clk);
    // Released lines show the inverse, never the stale value
    cfg_we = ~w;
    cfg_addr = ~a;
    cfg_din = ~d;
  endtask
endmodule
`default_nettype wire

// ---- sim/test_monitor_status_minmax_calib.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_monitor_status_minmax_calib;
  import msmc_pkg::*;
  logic CLK = 0, RST = 1, MEAS_VALID = 0, CONV_REQ = 0, BUSY, CAL_APPLIED;
  logic CFG_EN, CFG_WE, CFG_RDY, DEFAULT_MODE = 0, GPOS = 0, OT = 0, REFI = 0;
  logic RO = 0, DIS = 0;
  logic [1:0]  MEAS_SENSOR = 0;
  logic [3:0]  ENA = 0;
  logic [5:0]  CONV_CHAN = 0, GMAG = 0;
  logic [7:0]  CFG_ADDR;
  logic [9:0]  ESUP = 0, EBIP = 0;
  logic [11:0] ALM = 0;
  logic [15:0] CFG_DIN, CFG_DOUT, MEAS_DATA = 0, q, mx [4], mn [4];
  int n_mismatch = 0, checked = 0, n;
  logic [17:0] rows [8] = '{{2'd0, 16'h8000}, {2'd0, 16'h7fff}, {2'd0, 16'h8040},
    {2'd0, 16'h8040}, {2'd1, 16'h0000}, {2'd1, 16'hffff}, {2'd2, 16'h1234}, {2'd3, 16'hffc0}};
  always #2.5 CLK = ~CLK;
  msmc_status_bank i_msmc_status_bank (.CLK(CLK), .RST(RST), .CFG_EN(CFG_EN),
    .CFG_WE(CFG_WE), .CFG_ADDR(CFG_ADDR), .CFG_DIN(CFG_DIN), .CFG_DOUT(CFG_DOUT),
    .CFG_RDY(CFG_RDY), .MEAS_VALID(MEAS_VALID), .MEAS_SENSOR(MEAS_SENSOR),
    .MEAS_DATA(MEAS_DATA), .CONV_REQ(CONV_REQ), .CONV_CHAN(CONV_CHAN), .BUSY(BUSY),
    .CAL_ERR_SUPPLY(ESUP), .CAL_ERR_BIPOLAR(EBIP), .CAL_ERR_GAIN_POS(GPOS),
    .CAL_ERR_GAIN_MAG(GMAG), .DEFAULT_MODE(DEFAULT_MODE), .CALIBRATION_APPLY_ENABLES(ENA),
    .CAL_APPLIED(CAL_APPLIED), .ALARM_STATUS_BITS(ALM), .OVER_TEMPERATURE_FLAG(OT),
    .REF_INTERNAL(REFI), .DEBUG_ACCESS_READONLY_FLAG(RO), .DEBUG_ACCESS_DISABLED_FLAG(DIS));
  msmc_cfg_master i_msmc_cfg_master (.clk(CLK), .cfg_rdy(CFG_RDY), .cfg_dout(CFG_DOUT),
    .cfg_en(CFG_EN), .cfg_we(CFG_WE), .cfg_addr(CFG_ADDR), .cfg_din(CFG_DIN));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    i_msmc_cfg_master.access(1'b0, a, 16'h0000, v);
    chk(v, e);
  endtask
  // Result strobe; model tracks the stored value st
  task automatic put(input logic [1:0] s, input logic [15:0] d, input logic [15:0] st);
    @(negedge CLK);
    MEAS_VALID = 1'b1;
    MEAS_SENSOR = s;
    MEAS_DATA = d;
    if (st > mx[s]) mx[s] = st;
    if (st < mn[s]) mn[s] = st;
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(negedge CLK);
    RST = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      mx[s] = MAX_RESET;
      mn[s] = MIN_RESET;
      rd(MIN_BASE + s, MIN_RESET);
      rd(MAX_BASE + s, MAX_RESET);
    end
    foreach (rows[i])
    begin
      put(rows[i][17:16], rows[i][15:0], rows[i][15:0]);
      @(negedge CLK);
      MEAS_VALID = 1'b0;
      rd(MEAS_BASE + rows[i][17:16], rows[i][15:0]);
      rd(MAX_BASE + rows[i][17:16], mx[rows[i][17:16]]);
      rd(MIN_BASE + rows[i][17:16], mn[rows[i][17:16]]);
    end
    put(2'd2, 16'h0100, 16'h0100);
    put(2'd2, 16'hff00, 16'hff00);
    @(negedge CLK);
    MEAS_VALID = 1'b0;
    rd(MIN_BASE + 2, mn[2]);
    rd(MAX_BASE + 2, mx[2]);
    for (int p = 0; p < 2; p++)
    begin
      @(negedge CLK);
      ALM = p ? 12'h5aa : 12'ha55;
      {OT, REFI, RO, DIS} = p ? 4'h5 : 4'ha;
      rd(FLAG_MAIN_ADDR, {4'h0, DIS, RO, REFI, 1'b0, ALM[6:3], OT, ALM[2:0]});
      rd(FLAG_HIGH_ADDR, {12'h000, ALM[11:8]});
    end
    ESUP = 10'd10;
    EBIP = 10'h3fd;
    GPOS = 1'b1;
    GMAG = 6'd10;
    @(negedge CLK);
    CONV_REQ = 1'b1;
    CONV_CHAN = CAL_CHANNEL;
    @(negedge CLK);
    CONV_REQ = 1'b0;
    n = 0;
    while (BUSY === 1'b1 && n < 3000)
    begin
      CONV_REQ = (n == 5);
      n++;
      @(negedge CLK);
    end
    chk(n[15:0], CAL_CONV_GEN1 * CONV_CYCLES + 1);
    rd(SUPPLY_OFFSET_ADDR, 16'hfd80);
    rd(BIPOLAR_OFFSET_ADDR, 16'h00c0);
    rd(GAIN_COEFF_ADDR, 16'h000a);
    i_msmc_cfg_master.access(1'b1, SUPPLY_OFFSET_ADDR, 16'h1234, q);
    rd(SUPPLY_OFFSET_ADDR, 16'hfd80);
    rd(8'h50, UNMAPPED_RD);
    DEFAULT_MODE = 1'b1;
    @(negedge CLK);
    chk(CAL_APPLIED, 16'h0001);
    put(2'd3, 16'h0040, 16'hfdc0);
    @(negedge CLK);
    MEAS_VALID = 1'b0;
    DEFAULT_MODE = 1'b0;
    rd(MEAS_BASE + 3, 16'hfdc0);
    chk(CAL_APPLIED, 16'h0000);
    put(2'd3, 16'h0080, 16'h0080);
    @(negedge CLK);
    MEAS_VALID = 1'b0;
    ENA = 4'h2;
    rd(MEAS_BASE + 3, 16'h0080);
    chk(CAL_APPLIED, 16'h0001);
    rd(MIN_BASE + 3, mn[3]);
    @(negedge CLK);
    RST = 1'b1;
    @(negedge CLK);
    RST = 1'b0;
    rd(MIN_BASE + 3, MIN_RESET);
    rd(MAX_BASE + 3, MAX_RESET);
    report_and_stop();
  end
endmodule
`default_nettype wire
